/* File: common/swdrv_pkg.sv */
// Shared constants and types for the six-bit switch driver link
package swdrv_pkg;

	localparam int          WORD_W             = 6;
	localparam int          CORE_CLK_NS        = 50;
	localparam int          SCK_MIN_PERIOD_NS  = 100;
	localparam int          LINK_PERIOD_NS     = 400;
	localparam int          LE_MIN_WIDTH_NS    = 10;
	localparam int          LE_SPACING_NS      = 630;
	localparam int          POWERUP_MS         = 200;

	// Half period of the host-made shift clock, full period never below the minimum period
	localparam int SCK_HALF_CYCLES = (LINK_PERIOD_NS > SCK_MIN_PERIOD_NS ?
		LINK_PERIOD_NS : SCK_MIN_PERIOD_NS) / (2 * CORE_CLK_NS);
	localparam int LE_WIDTH_CYCLES = (LE_MIN_WIDTH_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
	localparam int LE_GAP_CYCLES   = (LE_SPACING_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
	localparam int POWERUP_CYCLES  = (POWERUP_MS * 1000000) / CORE_CLK_NS;

	// Power-up words selected by {high pin, low pin}
	localparam logic [5:0] PUP_WORD_00 = 6'h00;
	localparam logic [5:0] PUP_WORD_01 = 6'h10;
	localparam logic [5:0] PUP_WORD_10 = 6'h20;
	localparam logic [5:0] PUP_WORD_11 = 6'h3f;
	localparam logic [5:0] WORD_RESET  = 6'h00;

	typedef enum logic [1:0] {
		MODE_SERIAL  = 2'h0,
		MODE_LATCHED = 2'h1,
		MODE_DIRECT  = 2'h2
	} swdrv_mode_type;

endpackage : swdrv_pkg

/* File: common/swdrv_link_if.sv */
// Pin-level link between the switch driver and its host controller
`timescale 1ns/1ns
`default_nettype none
interface swdrv_link_if;
	logic       serial_parallel_select;
	logic       shift_clock;
	logic       serial_data_in;
	logic       output_load_strobe;
	logic [5:0] parallel_control_inputs;
	logic       powerup_select_low;
	logic       powerup_select_high;
	logic       serial_pass_through_out;
	logic [5:0] true_outputs;
	logic [5:0] complement_outputs;

	modport device (
		input  serial_parallel_select,
		input  shift_clock,
		input  serial_data_in,
		input  output_load_strobe,
		input  parallel_control_inputs,
		input  powerup_select_low,
		input  powerup_select_high,
		output serial_pass_through_out,
		output true_outputs,
		output complement_outputs
	);

	modport host (
		output serial_parallel_select,
		output shift_clock,
		output serial_data_in,
		output output_load_strobe,
		output parallel_control_inputs,
		output powerup_select_low,
		output powerup_select_high,
		input  serial_pass_through_out,
		input  true_outputs,
		input  complement_outputs
	);
endinterface : swdrv_link_if
`default_nettype wire

/* File: hw/swdrv_device.sv */
// Switch driver device end: serial/parallel input register and output latch
`timescale 1ns/1ns
`default_nettype none
module swdrv_device
	import swdrv_pkg::*;
#(
	parameter int POWERUP_CYCLES_P = POWERUP_CYCLES
) (
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       nrst,
	// Link pins
	swdrv_link_if.device    link,
	// User side status
	output logic [5:0]      word_out,
	output logic            powerup_done,
	output logic            word_update,
	output logic            shift_overrun
);

	////////////////////////////////////////////////////////////////////////////
	// Types

	typedef enum logic [1:0] {
		ST_POWERUP = 2'h1,
		ST_RUN     = 2'h2
	} swdrv_dev_state_type;

	// Synchronised pin bundle
	typedef struct packed {
		logic       sel;
		logic       sck;
		logic       din;
		logic       le;
		logic [5:0] par;
		logic       pup_lo;
		logic       pup_hi;
	} swdrv_pins_type;

	typedef struct packed {
		swdrv_dev_state_type st;
		swdrv_pins_type      s1;
		swdrv_pins_type      s2;
		logic                sck_last;
		logic [5:0]          shift;
		logic [5:0]          word;
		logic [5:0]          comp;
		logic [21:0]         cnt;
		logic [2:0]          nbits;
		logic                overrun;
		logic                update;
	} swdrv_dev_reg_type;

	localparam swdrv_dev_reg_type DEV_RESET = '{
		st:       ST_POWERUP,
		s1:       '0,
		s2:       '0,
		sck_last: 1'b0,
		shift:    WORD_RESET,
		word:     WORD_RESET,
		comp:     ~WORD_RESET,
		cnt:      22'h00_0000,
		nbits:    3'h0,
		overrun:  1'b0,
		update:   1'b0
	};

	localparam logic [21:0] PUP_LAST = 22'(POWERUP_CYCLES_P - 1);
	localparam logic [2:0]  NBITS_FULL = 3'(WORD_W);

	swdrv_dev_reg_type q;
	swdrv_dev_reg_type d;
	swdrv_pins_type    pins;
	logic              sck_rise;
	logic [5:0]        pup_word;
	logic              shift_take;
	logic              pup_due;
	logic [2:0]        nbits_step;
	logic              overrun_step;

	////////////////////////////////////////////////////////////////////////////
	// Pin capture

	always_comb begin
		pins.sel    = link.serial_parallel_select;
		pins.sck    = link.shift_clock;
		pins.din    = link.serial_data_in;
		pins.le     = link.output_load_strobe;
		pins.par    = link.parallel_control_inputs;
		pins.pup_lo = link.powerup_select_low;
		pins.pup_hi = link.powerup_select_high;
	end

	assign sck_rise = q.s2.sck & ~q.sck_last;

	////////////////////////////////////////////////////////////////////////////
	// Event qualification

	// Shift edge counts only with select high and strobe low
	assign shift_take = q.s2.sel & sck_rise & ~q.s2.le;
	// Last cycle of the power-up wait
	assign pup_due    = (q.st == ST_POWERUP) && (q.cnt == PUP_LAST);

	////////////////////////////////////////////////////////////////////////////
	// Bit count since the last load

	// Past a full word the oldest bits fall out; flag it
	always_comb begin
		nbits_step   = q.nbits;
		overrun_step = q.overrun;
		if (q.nbits == NBITS_FULL) begin
			overrun_step = 1'b1;
		end else begin
			nbits_step = q.nbits + 3'h1;
		end
	end

	// Power-up word lookup
	always_comb begin
		case ({q.s2.pup_hi, q.s2.pup_lo})
			2'h0:    pup_word = PUP_WORD_00;
			2'h1:    pup_word = PUP_WORD_01;
			2'h2:    pup_word = PUP_WORD_10;
			default: pup_word = PUP_WORD_11;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		d          = q;
		d.s1       = pins;
		d.s2       = q.s1;
		d.sck_last = q.s2.sck;
		d.update   = 1'b0;
		case (q.st)
			ST_POWERUP: begin
				d.cnt = q.cnt + 22'h00_0001;
				// Hold the reset word until the power-up delay runs out
				if (pup_due) begin
					if (q.s2.le) begin
						d.word = q.s2.par;
					end else begin
						d.word = pup_word;
					end
					d.shift  = d.word;
					d.update = 1'b1;
					d.st     = ST_RUN;
				end
			end
			ST_RUN: begin
				if (q.s2.sel) begin
					if (shift_take) begin
						d.shift   = {q.shift[4:0], q.s2.din};
						d.nbits   = nbits_step;
						d.overrun = overrun_step;
					end
				end else begin
					d.shift = q.s2.par;
				end
				// Transparent while high, frozen while low
				if (q.s2.le) begin
					d.word    = q.shift;
					d.update  = (q.shift != q.word);
					d.nbits   = 3'h0;
					d.overrun = 1'b0;
				end
			end
			default: begin
				d = DEV_RESET;
			end
		endcase
		d.comp = ~d.word;
	end

	////////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			q <= DEV_RESET;
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Complementary output pairs

	// One true/complement pair per control bit
	for (genvar b = 0; b < WORD_W; b++) begin : g_pair
		assign link.true_outputs[b]       = q.word[b];
		assign link.complement_outputs[b] = q.comp[b];
	end

	////////////////////////////////////////////////////////////////////////////
	// Pass-through and status

	// Oldest bit of the input register
	assign link.serial_pass_through_out = q.shift[5];
	assign word_out                     = q.word;
	assign powerup_done                 = (q.st == ST_RUN);
	assign word_update                  = q.update;
	assign shift_overrun                = q.overrun;

endmodule : swdrv_device
`default_nettype wire

/* File: hw/swdrv_host.sv */
// Switch driver host end: drives the serial or parallel control pins
`timescale 1ns/1ns
`default_nettype none
module swdrv_host
	import swdrv_pkg::*;
(
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       nrst,
	// Link pins
	swdrv_link_if.host      link,
	// Command port
	input  wire logic       cmd_valid,
	output logic            cmd_ready,
	input  wire logic [1:0] cmd_mode,
	input  wire logic [5:0] cmd_word,
	// Power-up selection levels
	input  wire logic       pup_low_in,
	input  wire logic       pup_high_in,
	input  wire logic       pup_strobe_in
);

	////////////////////////////////////////////////////////////////////////////
	// Types

	typedef enum logic [4:0] {
		HS_IDLE   = 5'h01,
		HS_SHIFT  = 5'h02,
		HS_SETTLE = 5'h04,
		HS_STROBE = 5'h08,
		HS_GAP    = 5'h10
	} swdrv_host_state_type;

	typedef struct packed {
		swdrv_host_state_type st;
		logic                 direct;
		logic                 booted;
		logic [5:0]           word;
		logic [2:0]           nbit;
		logic [2:0]           div;
		logic [3:0]           gap;
		logic                 sel;
		logic                 sck;
		logic                 din;
		logic                 le;
		logic [5:0]           par;
		logic                 pup_lo;
		logic                 pup_hi;
	} swdrv_host_reg_type;

	localparam swdrv_host_reg_type HOST_RESET = '{
		st: HS_IDLE, direct: 1'b0, booted: 1'b0, word: WORD_RESET, nbit: 3'h0,
		div: 3'h0, gap: 4'h0, sel: 1'b0, sck: 1'b0, din: 1'b0, le: 1'b0,
		par: WORD_RESET, pup_lo: 1'b0, pup_hi: 1'b0
	};

	localparam logic [2:0] DIV_LAST   = 3'(SCK_HALF_CYCLES - 1);
	localparam logic [2:0] NBIT_LAST  = 3'(WORD_W - 1);
	localparam logic [3:0] GAP_LAST   = 4'(LE_GAP_CYCLES - 1);

	swdrv_host_reg_type q;
	swdrv_host_reg_type d;
	logic               tick;

	// Half-period enable, also covers the least strobe width
	assign tick      = (q.div == DIV_LAST);
	assign cmd_ready = (q.st == HS_IDLE) && q.booted;

	////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		d     = q;
		d.div = tick ? 3'h0 : q.div + 3'h1;
		case (q.st)
			HS_IDLE: begin
				d.pup_lo = pup_low_in;
				d.pup_hi = pup_high_in;
				if (!q.booted) begin
					d.le     = pup_strobe_in;
					d.booted = 1'b1;
				end else if (cmd_valid) begin
					d.word   = cmd_word;
					d.direct = 1'b0;
					d.le     = 1'b0;
					case (cmd_mode)
						MODE_SERIAL: begin
							d.sel  = 1'b1;
							d.sck  = 1'b0;
							d.din  = cmd_word[5];
							d.nbit = 3'h0;
							d.st   = HS_SHIFT;
						end
						MODE_DIRECT: begin
							d.sel    = 1'b0;
							d.par    = cmd_word;
							d.le     = 1'b1;
							d.direct = 1'b1;
						end
						default: begin
							d.sel = 1'b0;
							d.par = cmd_word;
							d.gap = 4'h0;
							d.st  = HS_SETTLE;
						end
					endcase
				end
			end
			HS_SHIFT: begin
				if (tick) begin
					d.sck = ~q.sck;
					if (q.sck) begin
						d.word = {q.word[4:0], 1'b0};
						d.din  = q.word[4];
						d.nbit = q.nbit + 3'h1;
						if (q.nbit == NBIT_LAST) begin
							d.st = HS_STROBE;
						end
					end
				end
			end
			HS_SETTLE: begin
				// Strobe stays low a full spacing, also after a direct-mode level
				if (q.gap != GAP_LAST) begin
					d.gap = q.gap + 4'h1;
				end else if (tick) begin
					d.st = HS_STROBE;
				end
			end
			HS_STROBE: begin
				d.le = 1'b1;
				if (tick && q.le) begin
					d.le  = 1'b0;
					d.gap = 4'h0;
					d.st  = HS_GAP;
				end
			end
			HS_GAP: begin
				d.gap = q.gap + 4'h1;
				if (q.gap == GAP_LAST) begin
					d.st = HS_IDLE;
				end
			end
			default: begin
				d = HOST_RESET;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			q <= HOST_RESET;
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pin drive

	assign link.serial_parallel_select  = q.sel;
	assign link.shift_clock             = q.sck;
	assign link.serial_data_in          = q.din;
	assign link.output_load_strobe      = q.le;
	assign link.parallel_control_inputs = q.par;
	assign link.powerup_select_low      = q.pup_lo;
	assign link.powerup_select_high     = q.pup_hi;

endmodule : swdrv_host
`default_nettype wire

/* File: sim/swdrv_link_asserts.sv */
// Concurrent checks on the switch driver link pins
`timescale 1ns/1ns
`default_nettype none
module swdrv_link_asserts #(
	parameter int POWERUP_CYCLES_P = 20
) (
	// Clock and reset
	input wire logic       core_clk,
	input wire logic       nrst,
	// Link pins
	input wire logic       serial_parallel_select,
	input wire logic       shift_clock,
	input wire logic       serial_data_in,
	input wire logic       output_load_strobe,
	input wire logic [5:0] parallel_control_inputs,
	input wire logic       powerup_select_low,
	input wire logic       powerup_select_high,
	input wire logic       serial_pass_through_out,
	input wire logic [5:0] true_outputs,
	input wire logic [5:0] complement_outputs
);
	localparam int PUP_END = POWERUP_CYCLES_P + 8;
	logic [15:0] up_cnt_q;
	logic [5:0]  le_hist_q;
	logic [3:0]  low_cnt_q;
	logic        had_high_q;
	logic        done;
	assign done = (up_cnt_q == 16'(PUP_END));
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			up_cnt_q   <= 16'h0000;
			le_hist_q  <= 6'h00;
			low_cnt_q  <= 4'h0;
			had_high_q <= 1'b0;
		end else begin
			up_cnt_q   <= done ? up_cnt_q : up_cnt_q + 16'h0001;
			le_hist_q  <= {le_hist_q[4:0], output_load_strobe};
			low_cnt_q  <= output_load_strobe ? 4'h0 : low_cnt_q + {3'h0, low_cnt_q != 4'hf};
			had_high_q <= had_high_q | output_load_strobe;
		end
	end
	default clocking dc @(posedge core_clk); endclocking
	default disable iff (!nrst);
	////////////////////////////////////////////////////////////////////////////////
	comp_inverse_a: assert property (
		complement_outputs == ~true_outputs) else $error("complement not inverse");
	hold_low_a: assert property (
		done && !$stable(true_outputs) |-> le_hist_q != 6'h00) else $error("outputs moved, strobe low");
	mask_shift_a: assert property (
		(serial_parallel_select && output_load_strobe)[*3] |-> $stable(serial_pass_through_out))
		else $error("shift while strobe high");
	par_load_a: assert property (
		(done && !serial_parallel_select && $stable(parallel_control_inputs))[*6]
		|-> serial_pass_through_out == parallel_control_inputs[5]) else $error("parallel load missed");
	direct_follow_a: assert property (
		(done && !serial_parallel_select && output_load_strobe && $stable(parallel_control_inputs))[*7]
		|-> true_outputs == parallel_control_inputs) else $error("outputs not following");
	pup_code_a: assert property (
		up_cnt_q == 16'(PUP_END - 1) && !output_load_strobe |-> true_outputs ==
		{powerup_select_high, powerup_select_low, {4{powerup_select_high & powerup_select_low}}})
		else $error("power-up code word wrong");
	pup_par_a: assert property (
		up_cnt_q == 16'(PUP_END - 1) && output_load_strobe |-> true_outputs == parallel_control_inputs)
		else $error("power-up parallel word wrong");
	sck_high_a: assert property (
		$rose(shift_clock) |-> shift_clock[*2]) else $error("shift clock high too short");
	sck_low_a: assert property (
		$fell(shift_clock) |-> (!shift_clock)[*2]) else $error("shift clock low too short");
	le_gap_a: assert property (
		$rose(output_load_strobe) && had_high_q |-> low_cnt_q >= 4'hd) else $error("strobe gap short");
	din_setup_a: assert property (
		serial_parallel_select && $past(serial_parallel_select) && $changed(serial_data_in)
		|-> !shift_clock) else $error("data moved with clock high");
endmodule : swdrv_link_asserts
`default_nettype wire

/* File: sim/tb_six_bit_serial_parallel_switch_driver.sv */
// Testbench joining host and device ends of the switch driver link
`timescale 1ns/1ns
`default_nettype none
module tb_six_bit_serial_parallel_switch_driver;
	localparam int PUP_CYC = 20;
	logic       core_clk, nrst, cmd_valid, cmd_ready, pup_low_in, pup_high_in, pup_strobe_in;
	logic       powerup_done, word_update, shift_overrun;
	logic [1:0] cmd_mode;
	logic [5:0] cmd_word, word_out;
	int         err_count = 0;
	int         total_checks = 0;
	swdrv_link_if swdrv_link_if_i ();
	swdrv_device #(.POWERUP_CYCLES_P(PUP_CYC)) swdrv_device_i (.core_clk(core_clk), .nrst(nrst),
		.link(swdrv_link_if_i.device), .word_out(word_out), .powerup_done(powerup_done),
		.word_update(word_update), .shift_overrun(shift_overrun));
	swdrv_host swdrv_host_i (.core_clk(core_clk), .nrst(nrst), .link(swdrv_link_if_i.host),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_mode(cmd_mode), .cmd_word(cmd_word),
		.pup_low_in(pup_low_in), .pup_high_in(pup_high_in), .pup_strobe_in(pup_strobe_in));
	swdrv_link_asserts #(.POWERUP_CYCLES_P(PUP_CYC)) swdrv_link_asserts_i (.core_clk(core_clk),
		.nrst(nrst), .serial_parallel_select(swdrv_link_if_i.serial_parallel_select),
		.shift_clock(swdrv_link_if_i.shift_clock), .serial_data_in(swdrv_link_if_i.serial_data_in),
		.output_load_strobe(swdrv_link_if_i.output_load_strobe),
		.parallel_control_inputs(swdrv_link_if_i.parallel_control_inputs),
		.powerup_select_low(swdrv_link_if_i.powerup_select_low),
		.powerup_select_high(swdrv_link_if_i.powerup_select_high),
		.serial_pass_through_out(swdrv_link_if_i.serial_pass_through_out),
		.true_outputs(swdrv_link_if_i.true_outputs),
		.complement_outputs(swdrv_link_if_i.complement_outputs));
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	task automatic print_verdict();
		if (err_count == 0 && total_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : print_verdict
	task automatic check(input string what, input logic [5:0] seen, input logic [5:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// Bounded wait on powerup_done (1) or cmd_ready (0)
	task automatic wait_flag(input bit pick);
		int n;
		n = 0;
		while ((pick ? powerup_done : cmd_ready) !== 1'b1) begin
			@(negedge core_clk);
			n++;
			if (n > 400) begin
				err_count++;
				print_verdict();
			end
		end
	endtask : wait_flag
	task automatic check_word(input logic [5:0] exp);
		check("word_out", word_out, exp);
		check("true_outputs", swdrv_link_if_i.true_outputs, exp);
		check("complement_outputs", swdrv_link_if_i.complement_outputs, ~exp);
	endtask : check_word
	task automatic do_reset(input logic st, input logic hi, input logic lo, input logic [5:0] exp);
		@(negedge core_clk);
		nrst = 1'b0;
		pup_strobe_in = st;
		pup_high_in = hi;
		pup_low_in = lo;
		repeat (2) @(negedge core_clk);
		nrst = 1'b1;
		repeat (PUP_CYC - 4) @(negedge core_clk);
		check("early outputs", swdrv_link_if_i.true_outputs, 6'h00);
		wait_flag(1'b1);
		check("word_update", {5'h00, word_update}, 6'h01);
		repeat (10) @(negedge core_clk);
		check_word(exp);
	endtask : do_reset
	task automatic send(input logic [1:0] mode, input logic [5:0] w);
		wait_flag(1'b0);
		cmd_valid = 1'b1;
		cmd_mode = mode;
		cmd_word = w;
		@(negedge core_clk);
		cmd_valid = 1'b0;
		wait_flag(1'b0);
		repeat (6) @(negedge core_clk);
		check_word(w);
		if (mode == 2'h0) begin
			check("pass_through", {5'h00, swdrv_link_if_i.serial_pass_through_out},
				{5'h00, w[5]});
			check("overrun", {5'h00, shift_overrun}, 6'h00);
		end
	endtask : send
	////////////////////////////////////////////////////////////////////////////////
	task automatic s_powerup();
		logic [5:0] pup_exp [4];
		pup_exp = '{6'h00, 6'h10, 6'h20, 6'h3f};
		for (int i = 0; i < 4; i++) begin
			do_reset(1'b0, i[1], i[0], pup_exp[i]);
		end
		do_reset(1'b1, 1'b1, 1'b1, 6'h00);
		do_reset(1'b0, 1'b0, 1'b0, 6'h00);
	endtask : s_powerup
	task automatic s_serial();
		send(2'h0, 6'h2d);
		send(2'h0, 6'h12);
	endtask : s_serial
	task automatic s_latched();
		send(2'h1, 6'h35);
		repeat (30) @(negedge core_clk);
		check_word(6'h35);
		send(2'h3, 6'h2a);
	endtask : s_latched
	task automatic s_direct();
		send(2'h2, 6'h0a);
		send(2'h2, 6'h33);
		send(2'h1, 6'h1c);
		send(2'h0, 6'h21);
	endtask : s_direct
	initial begin
		nrst = 1'b0;
		cmd_valid = 1'b0;
		cmd_mode = 2'h0;
		cmd_word = 6'h00;
		pup_low_in = 1'b0;
		pup_high_in = 1'b0;
		pup_strobe_in = 1'b0;
		repeat (2) @(negedge core_clk);
		s_powerup();
		s_serial();
		s_latched();
		s_direct();
		print_verdict();
	end
endmodule : tb_six_bit_serial_parallel_switch_driver
`default_nettype wire
